// >>> rtl/adcctl_top.sv
// Converter control registers, sequencer and prescaler behind AXI4-Lite.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module adcctl_top
    import adcctl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic crystalClock,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic convStart,
    output logic [4:0] convChannel,
    output logic convPowerDown,
    output logic convClockEnable,
    input wire logic convDone,
    input wire logic [7:0] convData,
    output logic irq
);

    //////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    // Assertion is immediate; release waits two edges so that no register leaves
    // reset on an edge that is too close to the pin's rising transition.
    logic rstSync1_r;
    logic rstSync2_r;
    wire rstIn_n = rstSync2_r;

    // The reset is taken asynchronously and released on the clock.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end
        else
        begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register state.
    adcctl_ctrl_t ctrl_r; // Interrupt enable, continuous mode, channel.
    logic doneFlag_r; // Polled completion flag.
    logic convIrq_r; // Pending conversion interrupt request.
    logic [7:0] result_r; // Last conversion result.
    logic resultValid_r; // Low for the first result after power-up.
    logic clkSrc_r; // One selects bus clock, zero the crystal clock.
    logic [2:0] divSel_r; // Prescaler code.
    logic [1:0] irqStatus_r; // Sticky events: bit 0 completion, bit 1 stale result.
    logic [1:0] irqMask_r; // Enables for the sticky events.
    logic warmUp_r; // Set while the first conversion after power-up runs.

    //////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel. Address and data may arrive in either order.
    // Each half of a write is parked here until its partner arrives, so the
    // register update always sees a consistent address and data pair.
    logic awHeld_r; // Write address captured and waiting.
    logic wHeld_r; // Write data captured and waiting.
    // Word-aligned write address; five bits reach the mask register.
    logic [4:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic bValid_r;

    assign s_axi_awready = !awHeld_r && !bValid_r;
    assign s_axi_wready = !wHeld_r && !bValid_r;
    wire wrFire = awHeld_r && wHeld_r && !bValid_r;
    wire lane0 = wStrb_r[0];
    wire wrCtrl = wrFire && lane0 && (awAddr_r == ADCCTL_OFS_STATUS_CONTROL);
    wire wrClk = wrFire && lane0 && (awAddr_r == ADCCTL_OFS_CLOCK_CONFIG);
    wire wrIrqStatus = wrFire && lane0 && (awAddr_r == ADCCTL_OFS_IRQ_STATUS);
    wire wrIrqMask = wrFire && lane0 && (awAddr_r == ADCCTL_OFS_IRQ_MASK);
    wire wrMapped = (awAddr_r == ADCCTL_OFS_STATUS_CONTROL) ||
        (awAddr_r == ADCCTL_OFS_RESULT) || (awAddr_r == ADCCTL_OFS_CLOCK_CONFIG) ||
        (awAddr_r == ADCCTL_OFS_IRQ_STATUS) || (awAddr_r == ADCCTL_OFS_IRQ_MASK);
    logic [1:0] bResp_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;

    // Hold each half until both are present, then answer once.
    // A write with the low byte lane disabled is answered but changes nothing.
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 5'h00;
            wData_r <= 32'h0;
            wStrb_r <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[4:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (wrFire)
            begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                bValid_r <= 1'b1;
                bResp_r <= wrMapped ? 2'h0 : 2'h2; // Unmapped writes get SLVERR.
            end
            else if (bValid_r && s_axi_bready)
            begin
                bValid_r <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel, answered one cycle after the address.
    // Only one read is in flight: the address is refused while the answer waits,
    // which keeps the side effect of a result read tied to exactly one transfer.
    logic rValid_r;
    logic [31:0] rData_r;
    logic [1:0] rResp_r;
    assign s_axi_arready = !rValid_r;
    wire rdFire = s_axi_arvalid && s_axi_arready;
    // Byte lanes below a word are ignored; a misaligned address reads the word.
    wire [4:0] rdAddr = {s_axi_araddr[4:2], 2'h0};
    wire rdResult = rdFire && (rdAddr == ADCCTL_OFS_RESULT);
    // The done flag is only visible in polled mode, otherwise it reads zero.
    wire doneVisible = doneFlag_r && !ctrl_r.irqEnable;
    wire [7:0] ctrlRead = {doneVisible, ctrl_r.irqEnable, ctrl_r.continuous, ctrl_r.channel};
    wire [7:0] clkRead = {divSel_r, clkSrc_r, 4'h0};
    wire [31:0] rdMux =
        (rdAddr == ADCCTL_OFS_STATUS_CONTROL) ? {24'h0, ctrlRead} :
        (rdAddr == ADCCTL_OFS_RESULT) ? {24'h0, result_r} :
        (rdAddr == ADCCTL_OFS_CLOCK_CONFIG) ? {24'h0, clkRead} :
        (rdAddr == ADCCTL_OFS_IRQ_STATUS) ? {29'h0, resultValid_r, irqStatus_r} :
        (rdAddr == ADCCTL_OFS_IRQ_MASK) ? {30'h0, irqMask_r} : 32'h0;
    wire rdMapped = (rdAddr == ADCCTL_OFS_STATUS_CONTROL) ||
        (rdAddr == ADCCTL_OFS_RESULT) || (rdAddr == ADCCTL_OFS_CLOCK_CONFIG) ||
        (rdAddr == ADCCTL_OFS_IRQ_STATUS) || (rdAddr == ADCCTL_OFS_IRQ_MASK);
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;

    // Capture read data when the address is taken.
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            rValid_r <= 1'b0;
            rData_r <= 32'h0;
            rResp_r <= 2'h0;
        end
        else if (rdFire)
        begin
            rValid_r <= 1'b1;
            rData_r <= rdMux;
            rResp_r <= rdMapped ? 2'h0 : 2'h2;
        end
        else if (rValid_r && s_axi_rready)
        begin
            rValid_r <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Prescaler: source select then divide by a power of two.
    // The divided rate is a one-cycle enable, never a derived clock, so the whole
    // block stays in the bus clock domain. A change of divider code takes effect
    // on the running count, so the first period after a change may be short.
    // Software is expected to aim for a converter rate near 1 MHz.
    logic xtalPrev_r;
    logic [3:0] preCount_r;
    logic convTick_r;
    // The crystal clock is sampled as a level; a rising edge is one tick.
    // It must stay below half the bus clock for every edge to be seen.
    wire xtalTick = crystalClock && !xtalPrev_r;
    wire srcTick = clkSrc_r ? 1'b1 : xtalTick;
    wire [3:0] divMask = divSel_r[2] ? ADCCTL_DIV_MAX :
        (4'h1 << divSel_r[1:0]) - 4'h1;
    wire preWrap = srcTick && ((preCount_r & divMask) == divMask);
    assign convClockEnable = convTick_r;

    // Counts source ticks and emits one enable pulse per divided period.
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            xtalPrev_r <= 1'b0;
            preCount_r <= 4'h0;
            convTick_r <= 1'b0;
        end
        else
        begin
            xtalPrev_r <= crystalClock;
            convTick_r <= preWrap;
            if (preWrap)
            begin
                preCount_r <= 4'h0;
            end
            else if (srcTick)
            begin
                preCount_r <= preCount_r + 4'h1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.
    // IDLE waits for a control write, START waits for the next converter tick so
    // the start strobe is aligned with the core's clock, BUSY waits for done.
    // A conversion left running when power-off is selected is abandoned; its late
    // done strobe is ignored because the sequencer is no longer busy.
    adcctl_state_t state_r;
    adcctl_state_t state_nxt;
    wire powerOff = (ctrl_r.channel == ADCCTL_CH_POWER_OFF);
    wire convEnd = (state_r == ADCCTL_BUSY) && convDone;
    assign convPowerDown = powerOff;
    assign convChannel = ctrl_r.channel;
    assign convStart = (state_r == ADCCTL_START) && convTick_r;

    // A control write in IDLE requests a new conversion, as does continuous mode.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ADCCTL_IDLE:
                if (wrCtrl && (wData_r[4:0] != ADCCTL_CH_POWER_OFF))
                    state_nxt = ADCCTL_START;
            ADCCTL_START:
                if (convTick_r)
                    state_nxt = ADCCTL_BUSY;
            ADCCTL_BUSY:
                if (convDone)
                    state_nxt = ctrl_r.continuous ? ADCCTL_START : ADCCTL_IDLE;
            default:
                state_nxt = ADCCTL_IDLE;
        endcase
        // The channel code that holds after this edge decides power-off. Looking only
        // at the stored code would cancel the very write that leaves the all-ones
        // code, so the first conversion after power-up would never start.
        if (wrCtrl ? (wData_r[4:0] == ADCCTL_CH_POWER_OFF) : powerOff)
        begin
            state_nxt = ADCCTL_IDLE;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
            state_r <= ADCCTL_IDLE;
        else
            state_r <= state_nxt;
    end

    //////////////////////////////////////////////////////////////////////////
    // Control, flag and result registers.
    // Sticky events: bit 0 marks any completion, bit 1 a completion whose result
    // is stale because the converter was still settling after power-up. The
    // warm-up marker is used rather than the valid bit, which would also flag
    // the second result after power-up.
    wire [1:0] irqEvents = {convEnd && warmUp_r, convEnd};

    // Set beats clear for every hardware flag.
    // A software clear in the same cycle as a completion would otherwise lose an
    // event that nobody has seen yet.
    always_ff @(posedge clk_sys or negedge rstIn_n)
    begin
        if (!rstIn_n)
        begin
            ctrl_r <= '{irqEnable: 1'b0, continuous: 1'b0, channel: ADCCTL_RST_CHANNEL};
            doneFlag_r <= 1'b0;
            convIrq_r <= 1'b0;
            result_r <= 8'h0;
            resultValid_r <= 1'b0;
            warmUp_r <= 1'b1;
            clkSrc_r <= ADCCTL_RST_CLKSRC;
            divSel_r <= ADCCTL_RST_DIV;
            irqStatus_r <= 2'h0;
            irqMask_r <= 2'h0;
        end
        else
        begin
            // Bit 7 of the write data is ignored; software is expected to write zero.
            if (wrCtrl)
            begin
                ctrl_r.irqEnable <= wData_r[ADCCTL_POS_IRQEN];
                ctrl_r.continuous <= wData_r[ADCCTL_POS_CONT];
                ctrl_r.channel <= wData_r[4:0];
            end
            if (wrClk)
            begin
                clkSrc_r <= wData_r[ADCCTL_POS_CLKSRC];
                divSel_r <= wData_r[7:ADCCTL_POS_DIV];
            end
            if (wrIrqMask)
                irqMask_r <= wData_r[1:0];
            irqStatus_r <= (irqStatus_r & ~(wrIrqStatus ? wData_r[1:0] : 2'h0)) | irqEvents;
            // Polled flag: set at end in polled mode, cleared by a result read.
            if (convEnd && !ctrl_r.irqEnable)
                doneFlag_r <= 1'b1;
            else if (rdResult)
                doneFlag_r <= 1'b0;
            // Interrupt request: set at end, dropped by result read or control write.
            if (convEnd && ctrl_r.irqEnable)
                convIrq_r <= 1'b1;
            else if (rdResult || wrCtrl)
                convIrq_r <= 1'b0;
            if (convEnd)
            begin
                result_r <= convData;
                resultValid_r <= !warmUp_r;
                warmUp_r <= 1'b0;
            end
            // Powering off means the next first result is stale again.
            if (powerOff)
                warmUp_r <= 1'b1;
        end
    end

    // One level output: the conversion request of interrupt mode, or any sticky
    // event that software has unmasked.
    assign irq = convIrq_r || |(irqStatus_r & irqMask_r);

endmodule

`default_nettype wire

// >>> rtl/adcctl_pkg.sv
// Package of constants and types for the converter control block.
package adcctl_pkg;

    // Register byte addresses on the AXI4-Lite bus; five bits reach the mask.
    localparam logic [4:0] ADCCTL_OFS_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] ADCCTL_OFS_RESULT = 5'h04;
    localparam logic [4:0] ADCCTL_OFS_CLOCK_CONFIG = 5'h08;
    localparam logic [4:0] ADCCTL_OFS_IRQ_STATUS = 5'h0c;
    localparam logic [4:0] ADCCTL_OFS_IRQ_MASK = 5'h10;

    // Field positions in the status and control register.
    localparam int ADCCTL_POS_DONE = 7;
    localparam int ADCCTL_POS_IRQEN = 6;
    localparam int ADCCTL_POS_CONT = 5;

    // Field positions in the clock configuration register.
    localparam int ADCCTL_POS_CLKSRC = 4;
    localparam int ADCCTL_POS_DIV = 5;

    // Reset values.
    localparam logic [4:0] ADCCTL_RST_CHANNEL = 5'h1f;
    localparam logic [2:0] ADCCTL_RST_DIV = 3'h0;
    localparam logic ADCCTL_RST_CLKSRC = 1'b0;

    // Special channel codes.
    localparam logic [4:0] ADCCTL_CH_POWER_OFF = 5'h1f;
    localparam logic [4:0] ADCCTL_CH_HIGH_REF = 5'h1d;
    localparam logic [4:0] ADCCTL_CH_LOW_REF = 5'h1e;
    localparam logic [4:0] ADCCTL_CH_LAST_INPUT = 5'h0e;

    // Prescaler terminal count for divide by 16.
    localparam logic [3:0] ADCCTL_DIV_MAX = 4'hf;

    // Status and control fields travel together.
    typedef struct packed {
        logic irqEnable;
        logic continuous;
        logic [4:0] channel;
    } adcctl_ctrl_t;

    // Converter sequencing states.
    typedef enum logic [1:0] {
        ADCCTL_IDLE,
        ADCCTL_START,
        ADCCTL_BUSY
    } adcctl_state_t;

endpackage

// >>> testbench/adcctl_chk.sv
// Port checker for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module adcctl_chk
    import adcctl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic convStart,
    input wire logic [4:0] convChannel,
    input wire logic convPowerDown,
    input wire logic convDone,
    input wire logic irq
);
    logic irqEn_r, cont_r, rdCtrl_r;
    // A write and its data taken at the same edge.
    wire wrHs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    //////////////////////////////////////////////////////////////////////////
    // Shadow of the mode bits; assumes address and data arrive together.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqEn_r <= 1'b0;
            cont_r <= 1'b0;
            rdCtrl_r <= 1'b0;
        end
        else
        begin
            if (wrHs && s_axi_awaddr == ADCCTL_OFS_STATUS_CONTROL && s_axi_wstrb[0])
            begin
                irqEn_r <= s_axi_wdata[ADCCTL_POS_IRQEN];
                cont_r <= s_axi_wdata[ADCCTL_POS_CONT];
            end
            if (s_axi_arvalid && s_axi_arready)
                rdCtrl_r <= (s_axi_araddr == ADCCTL_OFS_STATUS_CONTROL);
        end
    end
    //////////////////////////////////////////////////////////////////////////
    pd_code_a: assert property (convPowerDown == (convChannel == ADCCTL_CH_POWER_OFF))
        else $error("power-down pin disagrees with channel code");
    off_nostart_a: assert property (convPowerDown |-> !convStart)
        else $error("start issued while powered off");
    start_pulse_a: assert property (convStart |=> !convStart)
        else $error("start strobe longer than one cycle");
    rst_state_a: assert property ($rose(rst_n) |-> convChannel == ADCCTL_RST_CHANNEL && !irq)
        else $error("wrong state leaving reset");
    single_halt_a: assert property (convDone && !cont_r |=> (!convStart) [*4])
        else $error("single mode restarted by itself");
    cont_restart_a: assert property (convDone && cont_r |-> ##[1:64] (convStart || !cont_r))
        else $error("continuous mode failed to restart");
    irq_raise_a: assert property (convDone && irqEn_r |-> ##[0:3] irq)
        else $error("no interrupt at completion");
    irq_flag_a: assert property (s_axi_rvalid && rdCtrl_r && irqEn_r |-> !s_axi_rdata[ADCCTL_POS_DONE])
        else $error("done flag read as one in interrupt mode");
    wr_answer_a: assert property (wrHs |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    cover property (convDone && irqEn_r);
    cover property (convDone && cont_r);
    cover property (s_axi_rvalid && rdCtrl_r);
endmodule
bind adcctl_top adcctl_chk chk_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .convStart,
    .convChannel, .convPowerDown, .convDone, .irq);
`default_nettype wire

// >>> testbench/adcctl_core_model.sv
// Behavioural model of the analog converter core.
`timescale 1ns/10ps
`default_nettype none
module adcctl_core_model
#(
    parameter int LATENCY = 10
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic convStart,
    input wire logic [4:0] convChannel,
    input wire logic convPowerDown,
    input wire logic convClockEnable,
    output logic convDone,
    output logic [7:0] convData
);
    logic busy_r;
    logic [4:0] ch_r;
    logic [7:0] last_r;
    int cnt_r;
    // Outside the done strobe the bus shows the inverse, never a stale match.
    assign convData = convDone ? last_r : ~last_r;
    //////////////////////////////////////////////////////////////////////////
    // Counts converter clock ticks after a start; the result encodes the channel.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            ch_r <= 5'h00;
            last_r <= 8'h00;
            cnt_r <= 0;
            convDone <= 1'b0;
        end
        else
        begin
            convDone <= 1'b0;
            if (convStart && !convPowerDown)
            begin
                busy_r <= 1'b1;
                ch_r <= convChannel;
                cnt_r <= 0;
            end
            else if (busy_r && convClockEnable)
            begin
                cnt_r <= cnt_r + 1;
                if (cnt_r == LATENCY - 1)
                begin
                    busy_r <= 1'b0;
                    convDone <= 1'b1;
                    last_r <= {3'h2, ch_r};
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb_adcctl_top.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module tb_adcctl_top;
    import adcctl_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, crystalClock = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    // Response ready lines stay high for the whole run.
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic convStart, convPowerDown, convClockEnable, convDone, irq;
    logic [4:0] convChannel;
    logic [7:0] convData;
    logic [7:0] cfg [8] = '{8'h00, 8'h20, 8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hf0};
    int perExp [8] = '{2, 4, 1, 2, 4, 8, 16, 16};
    logic [4:0] chans [4] = '{5'h00, 5'h0e, 5'h1d, 5'h1e};
    int failures = 0, cmp_count = 0, c;
    always #20 clk_sys = ~clk_sys;
    // Crystal clock rises every second bus cycle.
    always @(posedge clk_sys) crystalClock <= ~crystalClock;
    adcctl_top dut_u (.clk_sys, .rst_n, .crystalClock, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .convStart,
        .convChannel, .convPowerDown, .convClockEnable, .convDone, .convData, .irq);
    adcctl_core_model model_u (.clk_sys, .rst_n, .convStart, .convChannel, .convPowerDown,
        .convClockEnable, .convDone, .convData);
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Address and data are offered together and each dropped once taken.
    task automatic axWr(input logic [4:0] a, input logic [31:0] d);
        logic awOk = 1'b0, wOk = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            awOk |= s_axi_awready;
            wOk |= s_axi_wready;
            if (awOk) s_axi_awvalid <= 1'b0;
            if (wOk) s_axi_wvalid <= 1'b0;
        end while (!(awOk && wOk));
        do @(posedge clk_sys); while (!s_axi_bvalid);
        rs = s_axi_bresp;
    endtask
    task automatic axRd(input logic [4:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic rdChk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        axRd(a);
        chk(nm, e, rd & m);
    endtask
    task automatic waitDone();
        do @(posedge clk_sys); while (!convDone);
    endtask
    task automatic cntStarts(input int n);
        c = 0;
        repeat (n) @(posedge clk_sys) c += int'(convStart);
    endtask
    // The first pulse may follow a mid-count change, so two are skipped.
    task automatic tickPeriod();
        repeat (2) do @(posedge clk_sys); while (!convClockEnable);
        c = 0;
        do @(posedge clk_sys) c++; while (!convClockEnable);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, clocking, single, interrupt and continuous modes.
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdChk(ADCCTL_OFS_STATUS_CONTROL, 32'hff, 32'h1f, "ctrlReset");
        rdChk(ADCCTL_OFS_CLOCK_CONFIG, 32'hff, 32'h00, "clkReset");
        chk("powerDown", 1, convPowerDown);
        rdChk(5'h14, 32'hffffffff, 32'h0, "unmappedData");
        chk("unmappedResp", 2'b10, rs);
        axWr(5'h14, 32'h0);
        chk("unmappedWrResp", 2'b10, rs);
        axWr(ADCCTL_OFS_STATUS_CONTROL, 32'h00);
        chk("wrResp", 2'b00, rs);
        waitDone();
        rdChk(ADCCTL_OFS_IRQ_STATUS, 32'h4, 32'h0, "staleValid");
        foreach (cfg[i])
        begin
            axWr(ADCCTL_OFS_CLOCK_CONFIG, 32'(cfg[i]));
            rdChk(ADCCTL_OFS_CLOCK_CONFIG, 32'hf0, 32'(cfg[i]), "clkCfg");
            tickPeriod();
            chk("tickPeriod", perExp[i], c);
        end
        // Bus clock divided by 16 keeps the converter clock near 1 MHz.
        axWr(ADCCTL_OFS_CLOCK_CONFIG, 32'h90);
        foreach (chans[i])
        begin
            axWr(ADCCTL_OFS_STATUS_CONTROL, 32'(chans[i]));
            waitDone();
            chk("channel", 32'(chans[i]), 32'(convChannel));
            rdChk(ADCCTL_OFS_STATUS_CONTROL, 32'h80, 32'h80, "doneSet");
            rdChk(ADCCTL_OFS_RESULT, 32'hff, 32'({3'h2, chans[i]}), "result");
            rdChk(ADCCTL_OFS_STATUS_CONTROL, 32'h80, 32'h0, "doneClear");
            rdChk(ADCCTL_OFS_IRQ_STATUS, 32'h4, 32'h4, "resultValid");
            cntStarts(40);
            chk("singleHalt", 0, c);
        end
        // The mask stays clear here so only the pending request drives irq.
        axWr(ADCCTL_OFS_STATUS_CONTROL, 32'h45);
        waitDone();
        repeat (3) @(posedge clk_sys);
        chk("irqRaised", 1, irq);
        rdChk(ADCCTL_OFS_STATUS_CONTROL, 32'h80, 32'h0, "irqModeFlag");
        axWr(ADCCTL_OFS_IRQ_STATUS, 32'h7);
        axRd(ADCCTL_OFS_RESULT);
        repeat (2) @(posedge clk_sys);
        chk("irqAfterRead", 0, irq);
        axWr(ADCCTL_OFS_STATUS_CONTROL, 32'h45);
        waitDone();
        axWr(ADCCTL_OFS_IRQ_STATUS, 32'h7);
        axWr(ADCCTL_OFS_STATUS_CONTROL, 32'h05);
        repeat (2) @(posedge clk_sys);
        chk("irqAfterWrite", 0, irq);
        waitDone();
        // An unmasked sticky completion drives irq until a one clears it.
        axWr(ADCCTL_OFS_IRQ_MASK, 32'h1);
        rdChk(ADCCTL_OFS_IRQ_MASK, 32'h3, 32'h1, "irqMask");
        chk("irqSticky", 1, irq);
        rdChk(ADCCTL_OFS_IRQ_STATUS, 32'h3, 32'h1, "irqStatus");
        axWr(ADCCTL_OFS_IRQ_STATUS, 32'h1);
        chk("irqCleared", 0, irq);
        axWr(ADCCTL_OFS_IRQ_MASK, 32'h0);
        axWr(ADCCTL_OFS_STATUS_CONTROL, 32'h25);
        // About 176 cycles per conversion at this converter rate.
        cntStarts(2000);
        chk("contStarts", 1, c >= 8);
        axWr(ADCCTL_OFS_STATUS_CONTROL, 32'h1f);
        cntStarts(100);
        chk("offStarts", 0, c);
        chk("offPin", 1, convPowerDown);
        print_verdict();
    end
    // Watchdog well beyond the few thousand cycles the sequence needs.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
